// ### inc/srf_pkg.sv
/*
  package of the spectral result buffer: register offsets, field positions,
  reset values, sizes and the carrier types shared by the buffer files.
  assumes one 200 MHz clock and an active-low asynchronous reset.
*/
package srf_pkg;

  localparam logic [7:0] SRF_ADDR_SELECT = 8'hfc;
  localparam logic [7:0] SRF_ADDR_FILL = 8'hfd;
  localparam logic [7:0] SRF_ADDR_LOW = 8'hfe;
  localparam logic [7:0] SRF_ADDR_HIGH = 8'hff;
  localparam logic [7:0] SRF_SELECT_RST = 8'h00;
  localparam logic [7:0] SRF_ADDR_RST = 8'h00;
  localparam logic [7:0] SRF_SELECT_MASK = 8'h7f;
  localparam int SRF_ENTRY_W = 16;
  localparam int SRF_DEPTH = 128;
  localparam int SRF_FILL_W = 8;
  localparam int SRF_NUM_RESULTS = 6;
  localparam int SRF_NUM_ITEMS = 7;
  localparam int SRF_STATUS_BIT = 0;
  localparam int SRF_RESULT_LSB = 1;

  typedef struct packed {
    logic [7:0] status;
    logic [SRF_NUM_RESULTS-1:0][SRF_ENTRY_W-1:0] result;
  } srf_sample_s;

  typedef struct packed {
    logic addr_set;
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic rd;
  } srf_reg_req_s;

  typedef enum logic [0:0] {
    SRF_SEQ_IDLE = 1'b0,
    SRF_SEQ_PUSH = 1'b1
  } srf_seq_e;

endpackage : srf_pkg

// ### verilog/srf_fifo.sv
/*
  flip-flop fifo with valid/ready on both sides and a fill count.
  assumes a single clock; a pop and a push may share one cycle.
*/
`timescale 1ns/1ps
module srf_fifo
  import srf_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 128
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } srf_fifo_state_s;

  srf_fifo_state_s s_q, s_d;
  logic push, pop;

  assign in_ready_o = (s_q.count != FULL_COUNT);
  assign out_valid_o = (s_q.count != '0);
  assign out_data_o = s_q.mem[s_q.rptr];
  assign level_o = s_q.count;

  always_comb begin
    s_d = s_q;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    if (push) begin
      s_d.mem[s_q.wptr] = in_data_i;
      s_d.wptr = s_q.wptr + AW'(1);
    end
    if (pop) begin
      s_d.rptr = s_q.rptr + AW'(1);
    end
    if (push && !pop) begin
      s_d.count = s_q.count + (AW+1)'(1);
    end else if (pop && !push) begin
      s_d.count = s_q.count - (AW+1)'(1);
    end
  end

  // storage is cleared too, so a head read right after reset never shows unknown bits
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q.mem <= '0;
      s_q.wptr <= '0;
      s_q.rptr <= '0;
      s_q.count <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_fifo_never_over: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.count <= FULL_COUNT) else $error("fifo count above depth");

endmodule : srf_fifo

// ### verilog/srf_result_buffer.sv
/*
  spectral result buffer: gathers selected results and status per sample,
  holds them in a 128-entry fifo and serves the host over a byte register
  port with an auto-stepping address pointer.
  assumes the serial-bus slave in front turns each host byte into one
  strobe on the register port, and the measurement engine gives one
  sample pulse per completed cycle.
*/
`timescale 1ns/1ps
module srf_result_buffer
  import srf_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input srf_reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] reg_addr_o,
  input wire logic sample_valid_i,
  input srf_sample_s sample_i,
  output logic sample_ready_o,
  input wire logic overflow_clear_i,
  output logic overflow_o,
  output logic buffer_data_interrupt_o,
  output logic [SRF_FILL_W-1:0] buffer_fill_count_o,
  output logic [7:0] buffer_content_select_o
);

  typedef struct packed {
    logic [7:0] select;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic overflow;
    logic irq;
    logic [SRF_FILL_W-1:0] fill;
    srf_seq_e seq;
    logic [SRF_NUM_ITEMS-1:0] pend;
    srf_sample_s smp;
    logic smp_ready;
  } srf_state_s;

  srf_state_s s_q, s_d;

  logic push_valid;
  logic push_ready;
  logic [SRF_ENTRY_W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [SRF_ENTRY_W-1:0] pop_data;
  logic [SRF_FILL_W-1:0] fill_now;
  logic [7:0] acc_addr;
  logic [SRF_NUM_ITEMS-1:0] pick;

  // one entry of 16 bits, 128 deep: the whole 256-byte store
  srf_fifo #(
    .WIDTH(SRF_ENTRY_W),
    .DEPTH(SRF_DEPTH)
  ) u_store (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_data),
    .level_o(fill_now)
  );

  // a write or read in the same cycle as a pointer load acts on the new address
  assign acc_addr = reg_req_i.addr_set ? reg_req_i.addr : s_q.addr;

  // lowest pending item goes first: status, then results 0..5
  always_comb begin
    pick = '0;
    for (int i = SRF_NUM_ITEMS - 1; i >= 0; i--) begin
      if (s_q.pend[i]) begin
        pick = '0;
        pick[i] = 1'b1;
      end
    end
  end

  // results fill both bytes; the status entry carries a zero high byte
  always_comb begin
    push_data = '0;
    for (int i = 0; i < SRF_NUM_RESULTS; i++) begin
      if (pick[i + SRF_RESULT_LSB]) begin
        push_data = s_q.smp.result[i];
      end
    end
    if (pick[SRF_STATUS_BIT]) begin
      push_data = {8'h00, s_q.smp.status};
    end
  end

  // entries always offered while pending; a full store drops rather than stalls
  assign push_valid = (s_q.seq == SRF_SEQ_PUSH) && (s_q.pend != '0);

  // every byte taken at 0xff completes an entry, single or burst alike
  assign pop_ready = reg_req_i.rd && (acc_addr == SRF_ADDR_HIGH);

  always_comb begin
    s_d = s_q;
    // sample capture and per-item push sequence
    unique case (s_q.seq)
      SRF_SEQ_IDLE: begin
        if (sample_valid_i) begin
          s_d.smp = sample_i;
          s_d.pend = s_q.select[SRF_NUM_ITEMS-1:0];
          s_d.seq = SRF_SEQ_PUSH;
          s_d.smp_ready = 1'b0;
        end
      end
      SRF_SEQ_PUSH: begin
        if (s_q.pend == '0) begin
          s_d.seq = SRF_SEQ_IDLE;
          s_d.smp_ready = 1'b1;
        end else begin
          s_d.pend = s_q.pend & ~pick;
          if (!push_ready) begin
            s_d.overflow = 1'b1;
          end
        end
      end
    endcase
    // clear loses to a same-cycle overflow
    if (overflow_clear_i && !(push_valid && !push_ready)) begin
      s_d.overflow = 1'b0;
    end
    // register port
    s_d.addr = acc_addr;
    if (reg_req_i.wr) begin
      if (acc_addr == SRF_ADDR_SELECT) begin
        s_d.select = reg_req_i.wdata & SRF_SELECT_MASK;
      end
    end
    if (reg_req_i.rd) begin
      unique case (acc_addr)
        SRF_ADDR_SELECT: s_d.rdata = s_q.select;
        SRF_ADDR_FILL: s_d.rdata = fill_now;
        SRF_ADDR_LOW: s_d.rdata = pop_valid ? pop_data[7:0] : 8'h00;
        SRF_ADDR_HIGH: s_d.rdata = pop_valid ? pop_data[15:8] : 8'h00;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // pointer steps after every byte; the data pair folds back on itself
    if (reg_req_i.rd || reg_req_i.wr) begin
      if (acc_addr == SRF_ADDR_HIGH) begin
        s_d.addr = SRF_ADDR_LOW;
      end else begin
        s_d.addr = acc_addr + 8'h01;
      end
    end
    s_d.fill = fill_now;
    s_d.irq = (fill_now != '0);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q.select <= SRF_SELECT_RST;
      s_q.addr <= SRF_ADDR_RST;
      s_q.rdata <= 8'h00;
      s_q.overflow <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.fill <= '0;
      s_q.seq <= SRF_SEQ_IDLE;
      s_q.pend <= '0;
      s_q.smp <= '0;
      s_q.smp_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign reg_addr_o = s_q.addr;
  assign sample_ready_o = s_q.smp_ready;
  assign overflow_o = s_q.overflow;
  assign buffer_data_interrupt_o = s_q.irq;
  assign buffer_fill_count_o = s_q.fill;
  assign buffer_content_select_o = s_q.select;

  a_fill_in_range: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.fill <= 8'd128)
    else $error("fill count above 128");

  a_overflow_on_full: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (push_valid && !push_ready) |=> overflow_o)
    else $error("overflow not flagged");

  a_full_drops_entry: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (push_valid && !push_ready && !pop_ready) |=> $stable(fill_now))
    else $error("entry stored while full");

  a_addr_wraps: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.rd && acc_addr == SRF_ADDR_HIGH) |=> reg_addr_o == SRF_ADDR_LOW)
    else $error("pointer did not fold to low byte");

  a_pop_on_high: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (pop_ready && pop_valid && !(push_valid && push_ready)) |=> fill_now == $past(fill_now) - 8'd1)
    else $error("high byte read did not pop");

  a_low_keeps_fill: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.rd && acc_addr == SRF_ADDR_LOW && !push_valid) |=> $stable(fill_now))
    else $error("low byte read popped");

  a_empty_reads_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.rd && !pop_valid && (acc_addr == SRF_ADDR_LOW || acc_addr == SRF_ADDR_HIGH)) |=> reg_rdata_o == 8'h00)
    else $error("empty buffer returned data");

  a_irq_tracks_data: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ##1 buffer_data_interrupt_o == ($past(fill_now) != 8'd0))
    else $error("interrupt disagrees with fill");

  a_fill_read_value: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.rd && acc_addr == SRF_ADDR_FILL) |=> reg_rdata_o == $past(fill_now))
    else $error("fill count read wrong");

  a_select_reaches_store: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_q.seq == SRF_SEQ_IDLE && sample_valid_i) |=> s_q.pend == $past(s_q.select[6:0]))
    else $error("sample items not taken from select");

  a_reset_clears: assert property (@(posedge clk_i)
    $rose(nrst_i) |-> (buffer_fill_count_o == 8'd0 && !overflow_o && buffer_content_select_o == 8'h00))
    else $error("state not cleared by reset");

  a_reset_idle: assert property (@(posedge clk_i)
    $rose(nrst_i) |-> (reg_addr_o == SRF_ADDR_RST && reg_rdata_o == 8'h00 && sample_ready_o && !buffer_data_interrupt_o))
    else $error("port not idle after reset");

  a_select_masked: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.wr && acc_addr == SRF_ADDR_SELECT) |=> buffer_content_select_o == ($past(reg_req_i.wdata) & SRF_SELECT_MASK))
    else $error("select write not taken");

  a_select_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(reg_req_i.wr && acc_addr == SRF_ADDR_SELECT) |=> $stable(buffer_content_select_o))
    else $error("select changed without write");

  a_select_read_back: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.rd && acc_addr == SRF_ADDR_SELECT) |=> reg_rdata_o == $past(buffer_content_select_o))
    else $error("select read wrong");

  a_fill_out_lags: assert property (@(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> buffer_fill_count_o == $past(fill_now))
    else $error("fill output not one cycle behind");

  a_fill_read_only: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.wr && acc_addr == SRF_ADDR_FILL && !(push_valid && push_ready)) |=> $stable(fill_now))
    else $error("write to fill count had effect");

  a_rdata_stands: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !reg_req_i.rd |=> $stable(reg_rdata_o))
    else $error("read data changed without read");

  a_addr_steps: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ((reg_req_i.rd || reg_req_i.wr) && acc_addr != SRF_ADDR_HIGH) |=> reg_addr_o == $past(acc_addr) + 8'h01)
    else $error("pointer did not step");

  a_addr_loads: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.addr_set && !reg_req_i.rd && !reg_req_i.wr) |=> reg_addr_o == $past(reg_req_i.addr))
    else $error("pointer load lost");

  a_addr_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(reg_req_i.addr_set || reg_req_i.rd || reg_req_i.wr) |=> $stable(reg_addr_o))
    else $error("pointer moved without access");

  a_burst_pairs: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.rd && acc_addr == SRF_ADDR_LOW) |=> reg_addr_o == SRF_ADDR_HIGH)
    else $error("low byte not followed by high byte");

  a_pop_only_high: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!pop_ready && !(push_valid && push_ready)) |=> $stable(fill_now))
    else $error("entry left without high byte read");

  a_high_gives_head: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.rd && acc_addr == SRF_ADDR_HIGH && pop_valid) |=> reg_rdata_o == $past(pop_data[15:8]))
    else $error("high byte not from head");

  a_low_gives_head: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.rd && acc_addr == SRF_ADDR_LOW && pop_valid) |=> reg_rdata_o == $past(pop_data[7:0]))
    else $error("low byte not from head");

  a_empty_no_pop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_req_i.rd && !pop_valid && !(push_valid && push_ready)) |=> fill_now == 8'd0)
    else $error("empty read changed fill");

  a_irq_matches_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
    buffer_data_interrupt_o == (buffer_fill_count_o != 8'd0))
    else $error("interrupt disagrees with fill output");

  a_irq_high_held: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (fill_now != 8'd0) |=> buffer_data_interrupt_o)
    else $error("interrupt low while data held");

  a_fill_max_irq: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (buffer_fill_count_o == 8'd128) |-> buffer_data_interrupt_o)
    else $error("full buffer without interrupt");

  a_full_refuses: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (fill_now == 8'd128) |-> !push_ready)
    else $error("full store still accepts");

  a_push_counts: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (push_valid && push_ready && !(pop_ready && pop_valid)) |=> fill_now == $past(fill_now) + 8'd1)
    else $error("push did not raise fill");

  a_ready_drops: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (sample_valid_i && sample_ready_o) |=> !sample_ready_o)
    else $error("ready stayed high after sample");

  a_ready_when_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sample_ready_o == (s_q.seq == SRF_SEQ_IDLE))
    else $error("ready disagrees with sequencer");

  a_idle_no_push: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_q.seq == SRF_SEQ_IDLE) |-> !push_valid)
    else $error("push offered while idle");

  a_status_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (push_valid && s_q.pend[SRF_STATUS_BIT]) |-> push_data == {8'h00, s_q.smp.status})
    else $error("status not pushed first");

  a_result0_next: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (push_valid && s_q.pend[1:0] == 2'b10) |-> push_data == s_q.smp.result[0])
    else $error("first result out of order");

  a_pend_shrinks: assert property (@(posedge clk_i) disable iff (!nrst_i)
    push_valid |=> s_q.pend == ($past(s_q.pend) & ($past(s_q.pend) - 7'd1)))
    else $error("pending item not retired");

  a_overflow_sticky: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (overflow_o && !overflow_clear_i) |=> overflow_o)
    else $error("overflow dropped without clear");

  a_overflow_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!overflow_o && !(push_valid && !push_ready)) |=> !overflow_o)
    else $error("overflow without full push");

  a_overflow_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (overflow_clear_i && !(push_valid && !push_ready)) |=> !overflow_o)
    else $error("overflow clear ignored");

  a_drop_keeps_head: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (push_valid && !push_ready && !pop_ready) |=> $stable(pop_data))
    else $error("dropped entry disturbed head");

endmodule : srf_result_buffer

// ### tb/srf_host_model.sv
/*
  host model of the serial register port: one request per host byte.
  assumes the buffer answers a read one cycle after taking it.
*/
`timescale 1ns/1ps
module srf_host_model
  import srf_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output srf_reg_req_s req_o
);
  initial req_o = '0;

  // low byte lives at 0xfe, high byte at 0xff
  task automatic rd(input logic set, input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{addr_set: set, addr: a, wr: 1'b0, wdata: 8'h00, rd: 1'b1};
    @(posedge clk_i);
    req_o <= '0;
    #1;
    d = rdata_i;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{addr_set: 1'b1, addr: a, wr: 1'b1, wdata: d, rd: 1'b0};
    @(posedge clk_i);
    req_o <= '0;
  endtask : wr
endmodule : srf_host_model

// ### tb/srf_result_buffer_tb.sv
/*
  testbench of the result buffer: host model on the register port,
  samples driven directly. assumes 200 MHz clock, active-low reset.
*/
`timescale 1ns/1ps
module srf_result_buffer_tb;
  import srf_pkg::*;
  logic clk_i, nrst_i, sample_valid_i, overflow_clear_i, sready, ovf, irq;
  logic [7:0] rdata, addr, fill, sel;
  srf_sample_s sample_i;
  srf_reg_req_s req;
  int num_errors = 0;
  int num_checks = 0;

  srf_host_model host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
  srf_result_buffer dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_addr_o(addr), .sample_valid_i(sample_valid_i),
    .sample_i(sample_i), .sample_ready_o(sready),
    .overflow_clear_i(overflow_clear_i), .overflow_o(ovf),
    .buffer_data_interrupt_o(irq), .buffer_fill_count_o(fill),
    .buffer_content_select_o(sel));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdc(input logic s, input logic [7:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    host.rd(s, a, d);
    chk(nm, {8'h00, d}, {8'h00, exp});
  endtask : rdc

  // fill count and interrupt lag the store by a cycle, so let two pass
  task automatic lvl(input logic [7:0] exp);
    repeat (2) @(posedge clk_i);
    #1;
    chk("fill", {8'h00, fill}, {8'h00, exp});
    chk("irq", {15'h0, irq}, {15'h0, exp != 8'h00});
  endtask : lvl

  task automatic push(input logic [7:0] st);
    int n;
    @(posedge clk_i);
    sample_i.status <= st;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (sready !== 1'b1 && n < 20);
    chk("ready", {15'h0, sready}, 16'h0001);
  endtask : push

  task automatic t_reset;
    chk("sel", {8'h00, sel}, 16'h0000);
    chk("ovf", {15'h0, ovf}, 16'h0000);
    lvl(8'h00);
    rdc(1'b1, SRF_ADDR_FILL, 8'h00, "lvl reg");
    rdc(1'b1, SRF_ADDR_LOW, 8'h00, "empty low");
    rdc(1'b1, SRF_ADDR_HIGH, 8'h00, "empty high");
    host.wr(SRF_ADDR_SELECT, 8'hff);
    rdc(1'b1, SRF_ADDR_SELECT, 8'h7f, "sel rd");
  endtask : t_reset

  // status then result0, read as one burst that wraps 0xff to 0xfe
  task automatic t_burst;
    host.wr(SRF_ADDR_SELECT, 8'h03);
    push(8'ha5);
    lvl(8'h02);
    rdc(1'b1, SRF_ADDR_LOW, 8'ha5, "st low");
    rdc(1'b0, 8'h00, 8'h00, "st high");
    chk("wrap", {8'h00, addr}, {8'h00, SRF_ADDR_LOW});
    rdc(1'b0, 8'h00, 8'h5a, "r0 low");
    rdc(1'b0, 8'h00, 8'h01, "r0 high");
    lvl(8'h00);
  endtask : t_burst

  task automatic t_single;
    push(8'hc3);
    rdc(1'b1, SRF_ADDR_HIGH, 8'h00, "pop high");
    lvl(8'h01);
    rdc(1'b1, SRF_ADDR_LOW, 8'h5a, "next low");
    lvl(8'h01);
    rdc(1'b1, SRF_ADDR_HIGH, 8'h01, "next high");
    lvl(8'h00);
  endtask : t_single

  // 19 samples of 7 entries overrun 128; the head must survive
  task automatic t_over;
    host.wr(SRF_ADDR_SELECT, 8'h7f);
    for (int i = 0; i < 19; i++) begin
      push(8'h80 + 8'(i));
    end
    lvl(8'h80);
    chk("ovf", {15'h0, ovf}, 16'h0001);
    host.wr(SRF_ADDR_FILL, 8'h00);
    rdc(1'b1, SRF_ADDR_FILL, 8'h80, "lvl ro");
    rdc(1'b1, SRF_ADDR_LOW, 8'h80, "head");
    rdc(1'b0, 8'h00, 8'h00, "head high");
    @(posedge clk_i);
    overflow_clear_i <= 1'b1;
    @(posedge clk_i);
    overflow_clear_i <= 1'b0;
    lvl(8'h7f);
    chk("ovf clr", {15'h0, ovf}, 16'h0000);
  endtask : t_over

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200us;
    num_errors++;
    wrap_up();
  end

  initial begin
    nrst_i = 1'b0;
    sample_valid_i = 1'b0;
    overflow_clear_i = 1'b0;
    sample_i = '0;
    for (int k = 0; k < SRF_NUM_RESULTS; k++) begin
      sample_i.result[k] = {8'(k + 1), 8'h5a};
    end
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    t_reset();
    t_burst();
    t_single();
    t_over();
    wrap_up();
  end
endmodule : srf_result_buffer_tb
